// File: logic/wrc_pkg.sv
// Constants, register map and field layout for the watchdog and reset block.
// Assumes one 200 MHz clock; slow-clock ticks arrive as one-cycle strobes.
//
// Behaviour
// - Watchdog counts slow clock ticks from internal RC or external crystal.
// - Timeout select picks overflow at 2^8,10,12,14,15,16,17,18 slow cycles.
// - Enable code 10101 disables the watchdog, 01010 enables it.
// - Any other enable code resets the device after two to three RC ticks.
// - After power-up the enable code holds the enabling value.
// - Reset from a bad enable code sets the watchdog-register reset flag.
// - Watchdog-register reset flag clears only by software writing zero or by power-on reset.
// - Enabled counter overflow in normal operation resets the device.
// - Normal-mode timeout also sets the timeout status flag.
// - Timeout in idle mode sets flag, resets only PC and stack pointer.
// - Count clears on bad-code reset, clear instruction or halt.
// - Power-on reset zeroes PC and sets port data and direction high.
// - Low supply lasting beyond qualify time resets and sets its flag.
// - Low supply no longer than qualify time is ignored.
// - Threshold register accepts 55, 33, 99 and aa as valid codes.
// - Other threshold codes reset after two to three ticks and set flag.
// - Bad threshold code reset returns that register to its power-on value.
// - Real low-supply reset leaves threshold register unchanged.
// - Low-supply reset is disabled in power-down mode.
// - Reset-flag register bits 6 to 3 always read zero.
// - Halt into deepest sleep clears and stops watchdog; else resumes.
package wrc_pkg;
    localparam logic [1:0] WRC_ADDR_WDOG = 2'h0;
    localparam logic [1:0] WRC_ADDR_FLAGS = 2'h1;
    localparam logic [1:0] WRC_ADDR_THRESH = 2'h2;
    localparam logic [1:0] WRC_ADDR_STATUS = 2'h3;
    localparam logic [7:0] WRC_WDOG_RESET = 8'h53;
    localparam logic [7:0] WRC_THRESH_RESET = 8'h55;
    localparam logic [4:0] WRC_EN_OFF = 5'h15;
    localparam logic [4:0] WRC_EN_ON = 5'h0a;
    localparam logic [7:0] WRC_TH_2V1 = 8'h55;
    localparam logic [7:0] WRC_TH_2V55 = 8'h33;
    localparam logic [7:0] WRC_TH_3V15 = 8'h99;
    localparam logic [7:0] WRC_TH_3V8 = 8'haa;
    localparam int WRC_EN_LSB = 3;
    localparam int WRC_SYSON_BIT = 7;
    localparam int WRC_LOWF_BIT = 2;
    localparam int WRC_THF_BIT = 1;
    localparam int WRC_WRF_BIT = 0;
    localparam int WRC_CNT_W = 18;
    // Bad-code delay in RC ticks (two to three)
    localparam logic [1:0] WRC_BAD_TICKS = 2'h2;
    // Low-supply qualify time in ns and derived cycles
    localparam int WRC_QUAL_NS = 120000;
    localparam int WRC_QUAL_CYC = WRC_QUAL_NS / 5;
    typedef enum logic [1:0] {WRC_RUN, WRC_IDLE, WRC_DEEP} wrc_mode_t;
endpackage

// File: logic/wrc_watchdog.sv
// Watchdog, bad-code guards and low-supply reset for a small controller.
// Assumes rc_tick_in and xtal_tick_in are one-cycle strobes per slow clock edge.
`timescale 1ns/1ps
module wrc_watchdog
    import wrc_pkg::*;
#(
    parameter int QUAL_CYC = WRC_QUAL_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic por_in,
    input wire logic rc_tick_in,
    input wire logic xtal_tick_in,
    input wire logic use_xtal_in,
    input wire logic clr_wdog_in,
    input wire logic halt_in,
    input wire logic halt_deep_in,
    input wire logic halt_idle_in,
    input wire logic wake_in,
    input wire logic low_supply_in,
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic dev_reset_out,
    output logic pc_sp_reset_out,
    output logic port_init_out,
    output logic timeout_flag_out,
    output logic power_down_flag_out,
    output logic idle_sysclk_keep_on_out
);
    logic [7:0] watchdog_control_r;
    logic [7:0] low_voltage_threshold_select_r;
    logic idle_sysclk_keep_on_r;
    logic watchdog_reg_soft_reset_flag_r;
    logic threshold_reg_soft_reset_flag_r;
    logic low_supply_reset_flag_r;
    logic timeout_status_flag_r;
    logic power_down_flag_r;
    logic [WRC_CNT_W-1:0] cnt_r;
    logic [1:0] en_bad_cnt_r;
    logic [1:0] th_bad_cnt_r;
    logic [31:0] low_cnt_r;
    logic [31:0] low_run_r;
    logic dev_reset_r;
    logic pc_sp_reset_r;
    logic port_init_r;
    logic [7:0] rdata_r;
    wrc_mode_t mode_r;
    logic slow_tick;
    logic wd_enabled;
    logic en_bad_fire;
    logic th_bad_fire;
    logic wd_over;
    logic low_fire;
    logic wr_wdog;
    logic wr_thr;
    logic wr_flags;

    // Threshold code check, used by the threshold guard, the reset reload and assertions
    function automatic logic th_valid(input logic [7:0] c);
        return c == WRC_TH_2V1 || c == WRC_TH_2V55 ||
            c == WRC_TH_3V15 || c == WRC_TH_3V8;
    endfunction

    // Overflow tap from the timeout select field
    function automatic logic tap(input logic [WRC_CNT_W-1:0] c,
                                 input logic [2:0] s);
        logic r;
        r = 1'b0;
        unique case (s)
            3'h0: r = c[7];
            3'h1: r = c[9];
            3'h2: r = c[11];
            3'h3: r = c[13];
            3'h4: r = c[14];
            3'h5: r = c[15];
            3'h6: r = c[16];
            3'h7: r = c[17];
        endcase
        return r;
    endfunction

    // Bit index of the tap; the bits below it get the all-ones check
    function automatic logic [4:0] tap_pos(input logic [2:0] s);
        logic [4:0] p;
        p = 5'h7;
        unique case (s)
            3'h0: p = 5'h7;
            3'h1: p = 5'h9;
            3'h2: p = 5'hb;
            3'h3: p = 5'hd;
            3'h4: p = 5'he;
            3'h5: p = 5'hf;
            3'h6: p = 5'h10;
            3'h7: p = 5'h11;
        endcase
        return p;
    endfunction

    // Slow clock source and address decode
    assign slow_tick = use_xtal_in ? xtal_tick_in : rc_tick_in;
    assign wd_enabled = watchdog_control_r[7:WRC_EN_LSB] == WRC_EN_ON;
    assign wr_wdog = wr_in && addr_in == WRC_ADDR_WDOG;
    assign wr_thr = wr_in && addr_in == WRC_ADDR_THRESH;
    assign wr_flags = wr_in && addr_in == WRC_ADDR_FLAGS;
    assign en_bad_fire = rc_tick_in && en_bad_cnt_r == WRC_BAD_TICKS;
    assign th_bad_fire = rc_tick_in && th_bad_cnt_r == WRC_BAD_TICKS;
    // Overflow when the counter would step past the selected tap
    assign wd_over = wd_enabled && mode_r != WRC_DEEP && slow_tick &&
        tap(cnt_r, watchdog_control_r[2:0]) &&
        (cnt_r & ((18'h1 << tap_pos(watchdog_control_r[2:0])) - 18'h1))
        == ((18'h1 << tap_pos(watchdog_control_r[2:0])) - 18'h1);
    assign low_fire = low_supply_in && mode_r != WRC_DEEP &&
        low_cnt_r == 32'(QUAL_CYC);

    // Power mode tracking from halt and wake
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_r || wake_in || pc_sp_reset_r) begin
            mode_r <= WRC_RUN;
        end else if (halt_in) begin
            mode_r <= halt_deep_in ? WRC_DEEP :
                (halt_idle_in ? WRC_IDLE : WRC_RUN);
        end
    end

    // Watchdog counter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_r || pc_sp_reset_r) begin
            cnt_r <= '0;
        end else if (en_bad_fire || clr_wdog_in || halt_in) begin
            cnt_r <= '0;
        end else if (wd_enabled && mode_r != WRC_DEEP && slow_tick) begin
            cnt_r <= cnt_r + 18'h1;
        end
    end

    // Continuous code guards counting RC ticks
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_r) begin
            en_bad_cnt_r <= 2'h0;
            th_bad_cnt_r <= 2'h0;
        end else begin
            if (watchdog_control_r[7:WRC_EN_LSB] == WRC_EN_ON ||
                watchdog_control_r[7:WRC_EN_LSB] == WRC_EN_OFF) begin
                en_bad_cnt_r <= 2'h0;
            end else if (rc_tick_in && en_bad_cnt_r != WRC_BAD_TICKS) begin
                en_bad_cnt_r <= en_bad_cnt_r + 2'h1;
            end
            if (th_valid(low_voltage_threshold_select_r)) begin
                th_bad_cnt_r <= 2'h0;
            end else if (rc_tick_in && th_bad_cnt_r != WRC_BAD_TICKS) begin
                th_bad_cnt_r <= th_bad_cnt_r + 2'h1;
            end
        end
    end

    // Low-supply qualification counter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_r || !low_supply_in ||
            mode_r == WRC_DEEP) begin
            low_cnt_r <= 32'h0;
        end else if (low_fire) begin
            low_cnt_r <= 32'h0;
        end else if (low_cnt_r != 32'(QUAL_CYC)) begin
            low_cnt_r <= low_cnt_r + 32'h1;
        end
    end

    // Run length of low supply, kept apart from the qualify counter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !low_supply_in) begin
            low_run_r <= 32'h0;
        end else if (low_run_r != 32'hffffffff) begin
            low_run_r <= low_run_r + 32'h1;
        end
    end

    // Control registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || por_in) begin
            watchdog_control_r <= WRC_WDOG_RESET;
            low_voltage_threshold_select_r <= WRC_THRESH_RESET;
            idle_sysclk_keep_on_r <= 1'b0;
        end else if (dev_reset_r) begin
            watchdog_control_r <= WRC_WDOG_RESET;
            idle_sysclk_keep_on_r <= 1'b0;
            if (!th_valid(low_voltage_threshold_select_r)) begin
                low_voltage_threshold_select_r <= WRC_THRESH_RESET;
            end
        end else begin
            if (wr_wdog) begin
                watchdog_control_r <= wdata_in;
            end
            if (wr_thr) begin
                low_voltage_threshold_select_r <= wdata_in;
            end
            if (wr_flags) begin
                idle_sysclk_keep_on_r <= wdata_in[WRC_SYSON_BIT];
            end
        end
    end

    // Sticky reset-cause flags; hardware set wins over software clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || por_in) begin
            watchdog_reg_soft_reset_flag_r <= 1'b0;
            threshold_reg_soft_reset_flag_r <= 1'b0;
            low_supply_reset_flag_r <= 1'b0;
        end else begin
            if (en_bad_fire) begin
                watchdog_reg_soft_reset_flag_r <= 1'b1;
            end else if (wr_flags && !wdata_in[WRC_WRF_BIT]) begin
                watchdog_reg_soft_reset_flag_r <= 1'b0;
            end
            if (th_bad_fire) begin
                threshold_reg_soft_reset_flag_r <= 1'b1;
            end else if (wr_flags && !wdata_in[WRC_THF_BIT]) begin
                threshold_reg_soft_reset_flag_r <= 1'b0;
            end
            if (low_fire) begin
                low_supply_reset_flag_r <= 1'b1;
            end else if (wr_flags && !wdata_in[WRC_LOWF_BIT]) begin
                low_supply_reset_flag_r <= 1'b0;
            end
        end
    end

    // Status flags: timeout and power-down
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || por_in) begin
            timeout_status_flag_r <= 1'b0;
            power_down_flag_r <= 1'b0;
        end else if (wd_over) begin
            timeout_status_flag_r <= 1'b1;
        end else if (halt_in) begin
            timeout_status_flag_r <= 1'b0;
            power_down_flag_r <= 1'b1;
        end else if (clr_wdog_in) begin
            timeout_status_flag_r <= 1'b0;
            power_down_flag_r <= 1'b0;
        end
    end

    // Reset pulses toward the core
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            dev_reset_r <= 1'b0;
            pc_sp_reset_r <= 1'b0;
            port_init_r <= 1'b0;
        end else begin
            dev_reset_r <= en_bad_fire || th_bad_fire || low_fire ||
                (wd_over && mode_r == WRC_RUN);
            pc_sp_reset_r <= wd_over && mode_r != WRC_RUN;
            port_init_r <= por_in;
        end
    end

    // Register readback, one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_r <= 8'h0;
        end else if (rd_in) begin
            unique case (addr_in)
                WRC_ADDR_WDOG: rdata_r <= watchdog_control_r;
                WRC_ADDR_FLAGS: rdata_r <= {idle_sysclk_keep_on_r, 4'h0,
                    low_supply_reset_flag_r, threshold_reg_soft_reset_flag_r,
                    watchdog_reg_soft_reset_flag_r};
                WRC_ADDR_THRESH: rdata_r <= low_voltage_threshold_select_r;
                WRC_ADDR_STATUS: rdata_r <= {4'h0, wd_enabled,
                    mode_r == WRC_DEEP, power_down_flag_r,
                    timeout_status_flag_r};
            endcase
        end else begin
            rdata_r <= 8'h0;
        end
    end

    assign rdata_out = rdata_r;
    assign dev_reset_out = dev_reset_r;
    assign pc_sp_reset_out = pc_sp_reset_r;
    assign port_init_out = port_init_r;
    assign timeout_flag_out = timeout_status_flag_r;
    assign power_down_flag_out = power_down_flag_r;
    assign idle_sysclk_keep_on_out = idle_sysclk_keep_on_r;

    // Bad enable code held three RC ticks must raise reset
    property p_en_bad;
        @(posedge clk_in) disable iff (!rst_n_in)
        en_bad_fire |=> dev_reset_r;
    endproperty
    a_en_bad: assert property (p_en_bad) else $error("no code reset");

    property p_wrf_set;
        @(posedge clk_in) disable iff (!rst_n_in || por_in)
        en_bad_fire |=> watchdog_reg_soft_reset_flag_r;
    endproperty
    a_wrf_set: assert property (p_wrf_set) else $error("flag not set");

    property p_wrf_hold;
        @(posedge clk_in) disable iff (!rst_n_in || por_in)
        watchdog_reg_soft_reset_flag_r && !wr_flags |=>
            watchdog_reg_soft_reset_flag_r;
    endproperty
    a_wrf_hold: assert property (p_wrf_hold) else $error("flag lost");

    sequence s_run_over;
        wd_over && mode_r == WRC_RUN;
    endsequence
    property p_over;
        @(posedge clk_in) disable iff (!rst_n_in || por_in)
        s_run_over |=> dev_reset_r && timeout_status_flag_r;
    endproperty
    a_over: assert property (p_over) else $error("no timeout reset");

    property p_sleep_over;
        @(posedge clk_in) disable iff (!rst_n_in)
        wd_over && mode_r == WRC_IDLE |=> pc_sp_reset_r && !dev_reset_r;
    endproperty
    a_sleep_over: assert property (p_sleep_over) else $error("idle to");

    property p_clr;
        @(posedge clk_in) disable iff (!rst_n_in)
        clr_wdog_in || halt_in |=> cnt_r == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("count not cleared");

    property p_low_short;
        @(posedge clk_in) disable iff (!rst_n_in)
        low_fire |-> low_run_r >= 32'(QUAL_CYC);
    endproperty
    a_low_short: assert property (p_low_short) else $error("low");

    property p_deep_stop;
        @(posedge clk_in) disable iff (!rst_n_in)
        mode_r == WRC_DEEP |=> cnt_r == '0 && low_cnt_r == 32'h0;
    endproperty
    a_deep_stop: assert property (p_deep_stop) else $error("deep");

    property p_th_bad;
        @(posedge clk_in) disable iff (!rst_n_in || por_in)
        th_bad_fire |=> dev_reset_r && threshold_reg_soft_reset_flag_r;
    endproperty
    a_th_bad: assert property (p_th_bad) else $error("bad level code");

    sequence s_reset_bad_th;
        dev_reset_r && !th_valid(low_voltage_threshold_select_r);
    endsequence
    property p_th_reload;
        @(posedge clk_in) disable iff (!rst_n_in || por_in)
        s_reset_bad_th |=>
            low_voltage_threshold_select_r == WRC_THRESH_RESET;
    endproperty
    a_th_reload: assert property (p_th_reload) else $error("reload");

    property p_th_keep;
        @(posedge clk_in) disable iff (!rst_n_in || por_in)
        dev_reset_r && th_valid(low_voltage_threshold_select_r) |=>
            $stable(low_voltage_threshold_select_r);
    endproperty
    a_th_keep: assert property (p_th_keep) else $error("level lost");

    property p_flags_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
        rd_in && addr_in == WRC_ADDR_FLAGS |=> rdata_r[6:3] == 4'h0;
    endproperty
    a_flags_zero: assert property (p_flags_zero) else $error("bits");

    property p_off_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        watchdog_control_r[7:WRC_EN_LSB] == WRC_EN_OFF |=>
            cnt_r == $past(cnt_r) || cnt_r == '0;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("off");
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the watchdog and reset block.
// Assumes the register map and codes of wrc_pkg and a 200 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import wrc_pkg::*;
    localparam int QUAL = 8;
    logic clk_in, rst_n_in, por_in, rc_tick_in, xtal_tick_in, use_xtal_in;
    logic clr_wdog_in, halt_in, halt_deep_in, halt_idle_in, wake_in;
    logic low_supply_in, wr_in, rd_in;
    logic [1:0] addr_in;
    logic [7:0] wdata_in, rdata_out, rv;
    logic dev_reset_out, pc_sp_reset_out, port_init_out, timeout_flag_out;
    logic power_down_flag_out, idle_sysclk_keep_on_out, dv, ps;
    int n_errors, n_checks, rc_cnt, xt_cnt;
    wrc_watchdog #(.QUAL_CYC(QUAL)) i_wrc_watchdog (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .por_in(por_in), .rc_tick_in(rc_tick_in),
        .xtal_tick_in(xtal_tick_in), .use_xtal_in(use_xtal_in),
        .clr_wdog_in(clr_wdog_in), .halt_in(halt_in),
        .halt_deep_in(halt_deep_in), .halt_idle_in(halt_idle_in),
        .wake_in(wake_in), .low_supply_in(low_supply_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .dev_reset_out(dev_reset_out),
        .pc_sp_reset_out(pc_sp_reset_out), .port_init_out(port_init_out),
        .timeout_flag_out(timeout_flag_out),
        .power_down_flag_out(power_down_flag_out),
        .idle_sysclk_keep_on_out(idle_sysclk_keep_on_out));
    // Clock at 5 ns period
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Slow ticks: RC every 4 cycles, crystal every 6 cycles
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rc_cnt <= 0;
            xt_cnt <= 0;
            rc_tick_in <= 1'b0;
            xtal_tick_in <= 1'b0;
        end else begin
            rc_cnt <= (rc_cnt == 3) ? 0 : rc_cnt + 1;
            rc_tick_in <= (rc_cnt == 3);
            xt_cnt <= (xt_cnt == 5) ? 0 : xt_cnt + 1;
            xtal_tick_in <= (xt_cnt == 5);
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    localparam logic [2:0] P_CLR = 3'h1;
    localparam logic [2:0] P_HALT = 3'h2;
    localparam logic [2:0] P_WAKE = 3'h4;
    // One-cycle pulse on the instruction inputs picked by m
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_in);
        {wake_in, halt_in, clr_wdog_in} <= m;
        @(posedge clk_in);
        {wake_in, halt_in, clr_wdog_in} <= 3'h0;
    endtask
    // Watch n cycles and note any reset pulse
    task automatic watch(input int n);
        dv = 1'b0;
        ps = 1'b0;
        repeat (n) begin
            @(posedge clk_in);
            #1;
            if (dev_reset_out === 1'b1) dv = 1'b1;
            if (pc_sp_reset_out === 1'b1) ps = 1'b1;
        end
    endtask
    task automatic t_por();
        `CHK(port_init_out, 1'b1)
        rd(WRC_ADDR_WDOG, rv);
        `CHK(port_init_out, 1'b0)
        `CHK(rv, 8'h53)
        rd(WRC_ADDR_THRESH, rv);
        `CHK(rv, 8'h55)
        wr(WRC_ADDR_FLAGS, 8'h78);
        rd(WRC_ADDR_FLAGS, rv);
        `CHK(rv & 8'h78, 8'h00)
        $display("test por done");
    endtask
    // Overflow after t ticks of period p, select s, restarted by clear
    task automatic t_timeout(input logic xt, input int p,
                             input logic [2:0] s, input int t);
        use_xtal_in <= xt;
        wr(WRC_ADDR_WDOG, {WRC_EN_ON, s});
        pulse(P_CLR);
        watch((t - 16) * p);
        `CHK(dv, 1'b0)
        pulse(P_CLR);
        watch((t - 16) * p);
        `CHK(dv, 1'b0)
        `CHK(timeout_flag_out, 1'b0)
        watch(40 * p);
        `CHK(dv, 1'b1)
        `CHK(timeout_flag_out, 1'b1)
        rd(WRC_ADDR_WDOG, rv);
        `CHK(rv, 8'h53)
        $display("test timeout done");
    endtask
    task automatic t_enable();
        use_xtal_in <= 1'b0;
        wr(WRC_ADDR_WDOG, {WRC_EN_OFF, 3'h0});
        watch(300 * 4);
        `CHK(dv, 1'b0)
        wr(WRC_ADDR_FLAGS, 8'h00);
        wr(WRC_ADDR_WDOG, {5'h1b, 3'h0});
        watch(4);
        `CHK(dv, 1'b0)
        watch(5 * 4);
        `CHK(dv, 1'b1)
        rd(WRC_ADDR_FLAGS, rv);
        `CHK(rv[WRC_WRF_BIT], 1'b1)
        pulse(P_CLR);
        watch(8);
        rd(WRC_ADDR_FLAGS, rv);
        `CHK(rv[WRC_WRF_BIT], 1'b1)
        wr(WRC_ADDR_FLAGS, 8'h00);
        rd(WRC_ADDR_FLAGS, rv);
        `CHK(rv[WRC_WRF_BIT], 1'b0)
        $display("test enable done");
    endtask
    task automatic t_supply();
        wr(WRC_ADDR_THRESH, WRC_TH_2V55);
        rd(WRC_ADDR_THRESH, rv);
        `CHK(rv, 8'h33)
        low_supply_in <= 1'b1;
        repeat (QUAL / 2) @(posedge clk_in);
        low_supply_in <= 1'b0;
        watch(30);
        `CHK(dv, 1'b0)
        low_supply_in <= 1'b1;
        watch(QUAL + 12);
        low_supply_in <= 1'b0;
        `CHK(dv, 1'b1)
        watch(4);
        rd(WRC_ADDR_FLAGS, rv);
        `CHK(rv[WRC_LOWF_BIT], 1'b1)
        rd(WRC_ADDR_THRESH, rv);
        `CHK(rv, 8'h33)
        wr(WRC_ADDR_THRESH, 8'h12);
        watch(5 * 4);
        `CHK(dv, 1'b1)
        rd(WRC_ADDR_FLAGS, rv);
        `CHK(rv[WRC_THF_BIT], 1'b1)
        rd(WRC_ADDR_THRESH, rv);
        `CHK(rv, 8'h55)
        $display("test supply done");
    endtask
    task automatic t_sleep();
        wr(WRC_ADDR_WDOG, {WRC_EN_ON, 3'h0});
        halt_deep_in <= 1'b1;
        pulse(P_HALT);
        low_supply_in <= 1'b1;
        watch(300 * 4);
        low_supply_in <= 1'b0;
        `CHK(dv | ps, 1'b0)
        `CHK(power_down_flag_out, 1'b1)
        pulse(P_WAKE);
        halt_deep_in <= 1'b0;
        halt_idle_in <= 1'b1;
        pulse(P_HALT);
        watch(270 * 4);
        `CHK(ps, 1'b1)
        `CHK(dv, 1'b0)
        `CHK(timeout_flag_out, 1'b1)
        `CHK(power_down_flag_out, 1'b1)
        halt_idle_in <= 1'b0;
        pulse(P_WAKE);
        wr(WRC_ADDR_WDOG, {WRC_EN_OFF, 3'h0});
        $display("test sleep done");
    endtask
    // Stimulus: power-on reset, then every scenario in turn
    initial begin
        n_errors = 0;
        n_checks = 0;
        {use_xtal_in, clr_wdog_in} = 2'h0;
        {halt_in, halt_deep_in, halt_idle_in, wake_in} = 4'h0;
        {low_supply_in, wr_in, rd_in, rst_n_in} = 4'h0;
        addr_in = 2'h0;
        wdata_in = 8'h00;
        por_in = 1'b1;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        por_in <= 1'b0;
        #1;
        t_por();
        t_timeout(1'b0, 4, 3'h0, 256);
        t_timeout(1'b1, 6, 3'h0, 256);
        t_timeout(1'b0, 4, 3'h1, 1024);
        t_enable();
        t_supply();
        t_sleep();
        close_out();
    end
    // Watchdog against a hang
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule
